// ===== hdl/cbm_pkg.sv
// Constants and types shared by the branch and copy execution slice.
// Assumes an 8-bit core with a 32-entry register file and 16-bit word PC.
package cbm_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int PC_W   = 16;
	localparam int OFS_W  = 7;
	localparam int DATA_W = 8;
	localparam int IDX_W  = 5;
	localparam int REGS   = 32;

	// ----------------------------------------------------------------
	// Status register bit positions
	// ----------------------------------------------------------------
	localparam int SR_C = 0;
	localparam int SR_Z = 1;
	localparam int SR_N = 2;
	localparam int SR_V = 3;
	localparam int SR_S = 4;
	localparam int SR_H = 5;
	localparam int SR_T = 6;
	localparam int SR_I = 7;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [PC_W-1:0]   PC_RESET   = 16'h0000;
	localparam logic [DATA_W-1:0] SREG_RESET = 8'h00;
	localparam logic [DATA_W-1:0] REG_RESET  = 8'h00;

	// ----------------------------------------------------------------
	// Timing: cycles spent by each kind of instruction
	// ----------------------------------------------------------------
	localparam int CYC_NOT_TAKEN = 1;
	localparam int CYC_TAKEN     = 2;
	localparam int CYC_COPY      = 1;

	// ----------------------------------------------------------------
	// Operations
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_NONE                      = 4'h0,
		OP_BRANCH_SIGNED_GE          = 4'h1,
		OP_BRANCH_SIGNED_LT          = 4'h2,
		OP_BRANCH_HALFCARRY_SET      = 4'h3,
		OP_BRANCH_HALFCARRY_CLEAR    = 4'h4,
		OP_BRANCH_TRANSFER_BIT_SET   = 4'h5,
		OP_BRANCH_TRANSFER_BIT_CLEAR = 4'h6,
		OP_BRANCH_OVERFLOW_SET       = 4'h7,
		OP_BRANCH_OVERFLOW_CLEAR     = 4'h8,
		OP_BRANCH_IRQ_ENABLED        = 4'h9,
		OP_BRANCH_IRQ_DISABLED       = 4'ha,
		OP_COPY_SINGLE_REGISTER      = 4'hb,
		OP_COPY_REGISTER_PAIR        = 4'hc
	} op_t;

	typedef enum logic [1:0] {
		ST_ISSUE    = 2'b01,
		ST_REDIRECT = 2'b10
	} exec_state_t;

endpackage

// ===== hdl/exec_if.sv
// Interface joining the execution top to its condition and copy helpers.
// Assumes the top drives operands and reads back decisions combinationally.
`timescale 1ns/10ps
interface exec_if;
	import cbm_pkg::*;

	op_t                     op;
	logic [DATA_W-1:0]       sreg;
	logic                    is_branch;
	logic                    take;
	logic [IDX_W-1:0]        src;
	logic [IDX_W-1:0]        dst;
	logic [DATA_W-1:0]       rd_lo;
	logic [DATA_W-1:0]       rd_hi;
	logic [IDX_W-1:0]        rd_idx_lo;
	logic [IDX_W-1:0]        rd_idx_hi;
	logic                    wr_lo;
	logic                    wr_hi;
	logic [IDX_W-1:0]        wr_idx_lo;
	logic [IDX_W-1:0]        wr_idx_hi;
	logic [DATA_W-1:0]       wr_data_lo;
	logic [DATA_W-1:0]       wr_data_hi;

	modport top (
		output op, sreg, src, dst, rd_lo, rd_hi,
		input  is_branch, take, rd_idx_lo, rd_idx_hi,
		input  wr_lo, wr_hi, wr_idx_lo, wr_idx_hi, wr_data_lo, wr_data_hi
	);
	modport cond (
		input  op, sreg,
		output is_branch, take
	);
	modport copy (
		input  op, src, dst, rd_lo, rd_hi,
		output rd_idx_lo, rd_idx_hi,
		output wr_lo, wr_hi, wr_idx_lo, wr_idx_hi, wr_data_lo, wr_data_hi
	);
endinterface

// ===== hdl/branch_cond_eval.sv
// Decides whether a conditional branch is taken from the status flags.
// Assumes the status flags are stable for the issue cycle.
`timescale 1ns/10ps
module branch_cond_eval
	import cbm_pkg::*;
(
	exec_if.cond x
);

	// ----------------------------------------------------------------
	// Condition decode
	// ----------------------------------------------------------------
	logic signed_lt;

	assign signed_lt = x.sreg[SR_N] ^ x.sreg[SR_V];

	always_comb begin
		x.is_branch = 1'b1;
		x.take      = 1'b0;
		unique case (x.op)
			OP_BRANCH_SIGNED_GE:          x.take = ~signed_lt;       // [RL1]
			OP_BRANCH_SIGNED_LT:          x.take = signed_lt;        // [RL2]
			OP_BRANCH_HALFCARRY_SET:      x.take = x.sreg[SR_H];     // [RL3]
			OP_BRANCH_HALFCARRY_CLEAR:    x.take = ~x.sreg[SR_H];    // [RL4]
			OP_BRANCH_TRANSFER_BIT_SET:   x.take = x.sreg[SR_T];     // [RL5]
			OP_BRANCH_TRANSFER_BIT_CLEAR: x.take = ~x.sreg[SR_T];    // [RL6]
			OP_BRANCH_OVERFLOW_SET:       x.take = x.sreg[SR_V];     // [RL7]
			OP_BRANCH_OVERFLOW_CLEAR:     x.take = ~x.sreg[SR_V];    // [RL8]
			OP_BRANCH_IRQ_ENABLED:        x.take = x.sreg[SR_I];     // [RL9]
			OP_BRANCH_IRQ_DISABLED:       x.take = ~x.sreg[SR_I];    // [RL10]
			default:                      x.is_branch = 1'b0;
		endcase
	end

endmodule

// ===== hdl/reg_copy_unit.sv
// Works out register file reads and writes for the two copy operations.
// Assumes the top returns read data for the indices given, same cycle.
`timescale 1ns/10ps
module reg_copy_unit
	import cbm_pkg::*;
(
	exec_if.copy x
);

	// ----------------------------------------------------------------
	// Pair copies use even indices; the low bit is ignored on purpose
	// so an odd index cannot straddle two pairs.
	// ----------------------------------------------------------------
	logic is_pair;

	assign is_pair = (x.op == OP_COPY_REGISTER_PAIR);

	always_comb begin
		x.rd_idx_lo  = x.src;
		x.rd_idx_hi  = x.src;
		x.wr_idx_lo  = x.dst;
		x.wr_idx_hi  = x.dst;
		x.wr_lo      = 1'b0;
		x.wr_hi      = 1'b0;
		x.wr_data_lo = x.rd_lo;
		x.wr_data_hi = x.rd_hi;
		if (x.op == OP_COPY_SINGLE_REGISTER) begin
			x.wr_lo = 1'b1;                                      // [RL12]
		end else if (is_pair) begin
			x.rd_idx_lo = {x.src[IDX_W-1:1], 1'b0};
			x.rd_idx_hi = {x.src[IDX_W-1:1], 1'b1};
			x.wr_idx_lo = {x.dst[IDX_W-1:1], 1'b0};
			x.wr_idx_hi = {x.dst[IDX_W-1:1], 1'b1};
			x.wr_lo     = 1'b1;                                  // [RL13]
			x.wr_hi     = 1'b1;                                  // [RL13]
		end
	end

endmodule

// ===== hdl/cond_branch_and_move_exec.sv
// Execution slice for flag-tested relative branches and register copies.
// Assumes a decoder issues one operation per accepted cycle on plain
// ports, and that other core units reach the status flags and the
// register file through the side ports here.
`timescale 1ns/10ps

// How it works
// [RL1] Signed greater-or-equal jumps to PC+k+1 when N xor V is zero.
// [RL2] Signed less-than jumps to PC+k+1 when N xor V is one.
// [RL3] Half-carry-set jumps to PC+k+1 only when H is one.
// [RL4] Half-carry-clear jumps to PC+k+1 only when H is zero.
// [RL5] Transfer-bit-set jumps to PC+k+1 only when T is one.
// [RL6] Transfer-bit-clear jumps to PC+k+1 only when T is zero.
// [RL7] Overflow-set jumps to PC+k+1 only when V is one.
// [RL8] Overflow-clear jumps to PC+k+1 only when V is zero.
// [RL9] Interrupts-enabled jumps to PC+k+1 only when I is one.
// [RL10] Interrupts-disabled jumps to PC+k+1 only when I is zero.
// [RL11] No branch touches a flag and each finishes in one or two cycles.
// [RL12] A single copy moves source to destination in one cycle, flags kept.
// [RL13] A pair copy moves r+1:r to d+1:d in one cycle, flags kept; the code clears the low bit of r and d first.
// [RL14] A false branch takes one cycle, a true one two, for the refetch.
// [RL15] The offset is signed and sign-extended to PC width before adding.
module cond_branch_and_move_exec
	import cbm_pkg::*;
(
	input  wire logic              i_sys_clk,
	input  wire logic              i_rst,
	input  wire logic              i_issue_valid,
	input  wire op_t               i_op,
	input  wire logic [OFS_W-1:0]  i_offset,
	input  wire logic [IDX_W-1:0]  i_dst,
	input  wire logic [IDX_W-1:0]  i_src,
	input  wire logic              i_pc_load,
	input  wire logic [PC_W-1:0]   i_pc_value,
	input  wire logic              i_sreg_wr,
	input  wire logic [DATA_W-1:0] i_sreg_wdata,
	input  wire logic              i_rf_wr,
	input  wire logic [IDX_W-1:0]  i_rf_waddr,
	input  wire logic [DATA_W-1:0] i_rf_wdata,
	input  wire logic [IDX_W-1:0]  i_rf_raddr,
	output logic                   o_ready,
	output logic                   o_done,
	output logic                   o_taken,
	output logic [PC_W-1:0]        o_pc,
	output logic [DATA_W-1:0]      o_sreg,
	output logic [DATA_W-1:0]      o_rf_rdata
);

	// ----------------------------------------------------------------
	// Storage and decode
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] regs [REGS];
	exec_state_t       state;
	exec_state_t       next_state;
	logic              accept;
	logic              do_branch;
	logic              do_copy;
	logic [PC_W-1:0]   offset_ext;
	logic [PC_W-1:0]   next_pc;

	exec_if x ();

	assign accept = i_issue_valid & (state == ST_ISSUE);
	assign x.op   = accept ? i_op : OP_NONE;
	assign x.sreg = o_sreg;
	assign x.src  = i_src;
	assign x.dst  = i_dst;
	assign x.rd_lo = regs[x.rd_idx_lo];
	assign x.rd_hi = regs[x.rd_idx_hi];

	assign do_branch = accept & x.is_branch;
	assign do_copy   = x.wr_lo;

	// Backward branches need the sign bit copied up to the full PC width
	assign offset_ext = {{(PC_W-OFS_W){i_offset[OFS_W-1]}}, i_offset}; // [RL15]

	branch_cond_eval u_cond (
		.x (x.cond)
	);

	reg_copy_unit u_copy (
		.x (x.copy)
	);

	// ----------------------------------------------------------------
	// Sequencing: a taken branch holds issue for the refetch cycle
	// ----------------------------------------------------------------
	always_comb begin
		next_state = state;
		unique case (state)
			ST_ISSUE: begin
				if (do_branch && x.take) begin
					next_state = ST_REDIRECT;                        // [RL14]
				end
			end
			ST_REDIRECT: begin
				next_state = ST_ISSUE;                               // [RL11]
			end
			default: begin
				next_state = ST_ISSUE;
			end
		endcase
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			state   <= ST_ISSUE;
			o_ready <= 1'b1;
		end else begin
			state   <= next_state;
			o_ready <= (next_state == ST_ISSUE);
		end
	end

	// ----------------------------------------------------------------
	// Completion reporting
	// ----------------------------------------------------------------
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_done  <= 1'b0;
			o_taken <= 1'b0;
		end else begin
			// Not-taken branch and copies finish in their issue cycle
			o_done  <= (do_branch && !x.take) || do_copy ||
				(state == ST_REDIRECT);                              // [RL14]
			o_taken <= (state == ST_REDIRECT);
		end
	end

	// ----------------------------------------------------------------
	// Program counter
	// ----------------------------------------------------------------
	always_comb begin
		next_pc = o_pc;
		if (do_branch && x.take) begin
			next_pc = o_pc + offset_ext + 16'h0001;                  // [RL1]
		end else if (do_branch || do_copy) begin
			next_pc = o_pc + 16'h0001;
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_pc <= PC_RESET;
		end else if (i_pc_load) begin
			// An outside load wins; the slice owns no other PC source
			o_pc <= i_pc_value;
		end else begin
			o_pc <= next_pc;
		end
	end

	// ----------------------------------------------------------------
	// Status flags: only outside writers change them
	// ----------------------------------------------------------------
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_sreg <= SREG_RESET;
		end else if (i_sreg_wr) begin
			o_sreg <= i_sreg_wdata;                                  // [RL11]
		end
	end

	// ----------------------------------------------------------------
	// Register file, one entry per loop pass; a copy beats the side
	// write port when both hit the same entry in one cycle.
	// ----------------------------------------------------------------
	for (genvar g = 0; g < REGS; g++) begin : g_reg
		localparam logic [IDX_W-1:0] IDX = IDX_W'(g);
		always_ff @(posedge i_sys_clk or posedge i_rst) begin
			if (i_rst) begin
				regs[g] <= REG_RESET;
			end else if (x.wr_hi && x.wr_idx_hi == IDX) begin
				regs[g] <= x.wr_data_hi;                             // [RL13]
			end else if (x.wr_lo && x.wr_idx_lo == IDX) begin
				regs[g] <= x.wr_data_lo;                             // [RL12]
			end else if (i_rf_wr && i_rf_waddr == IDX) begin
				regs[g] <= i_rf_wdata;
			end
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_rf_rdata <= REG_RESET;
		end else begin
			o_rf_rdata <= regs[i_rf_raddr];
		end
	end

endmodule

// ===== sim/cbm_props.sv
// Assertion checker for the branch and copy execution slice.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/10ps
module cbm_props
	import cbm_pkg::*;
(
	input wire logic              i_sys_clk,
	input wire logic              i_rst,
	input wire logic              i_issue_valid,
	input wire op_t               i_op,
	input wire logic [OFS_W-1:0]  i_offset,
	input wire logic [IDX_W-1:0]  i_dst,
	input wire logic [IDX_W-1:0]  i_src,
	input wire logic              i_pc_load,
	input wire logic [PC_W-1:0]   i_pc_value,
	input wire logic              i_sreg_wr,
	input wire logic [DATA_W-1:0] i_sreg_wdata,
	input wire logic              i_rf_wr,
	input wire logic [IDX_W-1:0]  i_rf_waddr,
	input wire logic [DATA_W-1:0] i_rf_wdata,
	input wire logic [IDX_W-1:0]  i_rf_raddr,
	input wire logic              o_ready,
	input wire logic              o_done,
	input wire logic              o_taken,
	input wire logic [PC_W-1:0]   o_pc,
	input wire logic [DATA_W-1:0] o_sreg,
	input wire logic [DATA_W-1:0] o_rf_rdata
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);
	// ----------
	// Properties
	// ----------
	logic            iss, br, cp, tk;
	logic [10:1]     cv;
	logic [PC_W-1:0] tgt;
	// Condition per operation code, indexed by the code itself
	always_comb begin
		iss = i_issue_valid && o_ready;
		br = i_op inside {[OP_BRANCH_SIGNED_GE:OP_BRANCH_IRQ_DISABLED]};
		cp = i_op inside {OP_COPY_SINGLE_REGISTER, OP_COPY_REGISTER_PAIR};
		cv = {!o_sreg[SR_I], o_sreg[SR_I], !o_sreg[SR_V], o_sreg[SR_V],
			!o_sreg[SR_T], o_sreg[SR_T], !o_sreg[SR_H], o_sreg[SR_H],
			o_sreg[SR_N] ^ o_sreg[SR_V], !(o_sreg[SR_N] ^ o_sreg[SR_V])};
		tk = br && cv[i_op];
		tgt = o_pc + {{(PC_W-OFS_W){i_offset[OFS_W-1]}}, i_offset} + 16'h0001;
	end
	sequence s_refetch;
		!o_ready && !o_done ##1 o_ready && o_done && o_taken;
	endsequence
	a_taken_two_cycles: assert property (
		iss && tk |=> s_refetch)
		else $error("taken branch not done in two cycles");
	a_untaken_one_cycle: assert property (
		iss && br && !tk |=> o_done && !o_taken && o_ready)
		else $error("untaken branch not done in one cycle");
	a_copy_one_cycle: assert property (
		iss && cp |=> o_done && !o_taken && o_ready)
		else $error("copy not done in one cycle");
	a_jump_target: assert property (
		iss && tk && !i_pc_load |=> o_pc == $past(tgt))
		else $error("branch target wrong");
	a_next_word: assert property (
		iss && (cp || br && !tk) && !i_pc_load
		|=> o_pc == $past(o_pc) + 16'h0001)
		else $error("sequential step wrong");
	a_flags_kept: assert property (
		!i_sreg_wr |=> o_sreg == $past(o_sreg))
		else $error("status flags changed");
	a_ready_returns: assert property (
		!o_ready |=> o_ready)
		else $error("ready low for more than one cycle");
	a_taken_after_stall: assert property (
		o_taken |-> o_done && $past(o_ready) == 1'h0)
		else $error("taken pulse out of place");
endmodule
bind cond_branch_and_move_exec cbm_props u_props (
	.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_issue_valid(i_issue_valid),
	.i_op(i_op), .i_offset(i_offset), .i_dst(i_dst), .i_src(i_src),
	.i_pc_load(i_pc_load), .i_pc_value(i_pc_value), .i_sreg_wr(i_sreg_wr),
	.i_sreg_wdata(i_sreg_wdata), .i_rf_wr(i_rf_wr), .i_rf_waddr(i_rf_waddr),
	.i_rf_wdata(i_rf_wdata), .i_rf_raddr(i_rf_raddr), .o_ready(o_ready),
	.o_done(o_done), .o_taken(o_taken), .o_pc(o_pc), .o_sreg(o_sreg),
	.o_rf_rdata(o_rf_rdata)
);

// ===== sim/cond_branch_and_move_exec_bench.sv
// Self-checking bench for the branch and copy execution slice.
// Assumes the package, design and checker files are compiled first.
`timescale 1ns/10ps
module cond_branch_and_move_exec_bench;
	import cbm_pkg::*;
	typedef struct packed {
		logic [7:0]  s;
		logic [6:0]  k;
		logic [10:1] m;
	} row_t;
	logic        clk, rst, v, pl, sw, rw, rdy, dn, tkn;
	op_t         op;
	logic [6:0]  k;
	logic [4:0]  d, s, wa, ra;
	logic [15:0] pv, pc;
	logic [7:0]  sd, wd, sr, rd, es;
	logic [26:0] obs;
	int          fails, samples_checked;
	row_t        rows [4];
	row_t        r;
	assign obs = {dn, tkn, rdy, pc, sr};
	cond_branch_and_move_exec DUT (
		.i_sys_clk(clk), .i_rst(rst), .i_issue_valid(v), .i_op(op),
		.i_offset(k), .i_dst(d), .i_src(s), .i_pc_load(pl),
		.i_pc_value(pv), .i_sreg_wr(sw), .i_sreg_wdata(sd), .i_rf_wr(rw),
		.i_rf_waddr(wa), .i_rf_wdata(wd), .i_rf_raddr(ra), .o_ready(rdy),
		.o_done(dn), .o_taken(tkn), .o_pc(pc), .o_sreg(sr), .o_rf_rdata(rd)
	);
	task automatic chk(string n, logic [39:0] got, logic [39:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", n, exp, got);
		end
	endtask
	// Valid stays high on return, so calls run back to back and the
	// second cycle of a taken branch offers an issue that must be ignored
	task automatic issue(op_t o, logic [6:0] kk, logic tk);
		logic [15:0] t;
		t = pc + 16'h0001;
		if (tk)
			t = t + {{9{kk[6]}}, kk};
		op = o;
		k = kk;
		v = 1'h1;
		@(negedge clk);
		chk("issue", obs, {!tk, 1'h0, !tk, t, es});
		if (tk) begin
			@(negedge clk);
			chk("refetch", obs, {3'h7, t, es});
		end
	endtask
	task automatic wr(logic [4:0] a, logic [7:0] x);
		rw = 1'h1;
		wa = a;
		wd = x;
		@(negedge clk);
	endtask
	task automatic rdchk(logic [4:0] a, logic [7:0] x);
		ra = a;
		@(negedge clk);
		chk("reg", rd, x);
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end
	// --------
	// Sequence
	// --------
	initial begin
		// Rows: flags, offset, taken mask by operation code
		rows = '{'{8'he8, 7'h40, 10'h156}, '{8'h00, 7'h3f, 10'h2a9},
			'{8'h0c, 7'h00, 10'h269}, '{8'h04, 7'h7f, 10'h2aa}};
		{rst, v, pl, sw, rw} = 5'h10;
		op = OP_NONE;
		{k, d, s, wa, ra} = 27'h0;
		{pv, sd, wd, es} = 40'h0;
		repeat (6) @(negedge clk);
		rst = 1'h0;
		chk("reset", {obs, rd}, 35'h100000000);
		// Start low so the first backward offset wraps the counter
		pl = 1'h1;
		pv = 16'h0010;
		@(negedge clk) pl = 1'h0;
		chk("load", pc, 16'h0010);
		$display("test reset done");
		foreach (rows[i]) begin
			v = 1'h0;
			sw = 1'h1;
			sd = rows[i].s;
			@(negedge clk) sw = 1'h0;
			es = rows[i].s;
			r = rows[i];
			issue(OP_BRANCH_SIGNED_GE, r.k, r.m[1]);
			issue(OP_BRANCH_SIGNED_LT, r.k, r.m[2]);
			issue(OP_BRANCH_HALFCARRY_SET, r.k, r.m[3]);
			issue(OP_BRANCH_HALFCARRY_CLEAR, r.k, r.m[4]);
			issue(OP_BRANCH_TRANSFER_BIT_SET, r.k, r.m[5]);
			issue(OP_BRANCH_TRANSFER_BIT_CLEAR, r.k, r.m[6]);
			issue(OP_BRANCH_OVERFLOW_SET, r.k, r.m[7]);
			issue(OP_BRANCH_OVERFLOW_CLEAR, r.k, r.m[8]);
			issue(OP_BRANCH_IRQ_ENABLED, r.k, r.m[9]);
			issue(OP_BRANCH_IRQ_DISABLED, r.k, r.m[10]);
		end
		v = 1'h0;
		$display("test branches done");
		wr(5'h04, 8'h3c);
		wr(5'h05, 8'ha7);
		rw = 1'h0;
		d = 5'h09;
		s = 5'h04;
		issue(OP_COPY_SINGLE_REGISTER, 7'h00, 1'h0);
		d = 5'h0b;
		s = 5'h05;
		issue(OP_COPY_REGISTER_PAIR, 7'h00, 1'h0);
		v = 1'h0;
		rdchk(5'h09, 8'h3c);
		rdchk(5'h0a, 8'h3c);
		rdchk(5'h0b, 8'ha7);
		$display("test copies done");
		rst = 1'h1;
		@(negedge clk) rst = 1'h0;
		chk("rereset", {obs, rd}, 35'h100000000);
		rdchk(5'h09, 8'h00);
		$display("test second reset done");
		// An empty code is ignored: no done pulse, PC and flags held
		op = OP_NONE;
		v = 1'h1;
		@(negedge clk) v = 1'h0;
		chk("refused", obs, 27'h1000000);
		$display("test refused code done");
		wrap_up();
	end
endmodule
